// >>> hw/tim_pkg.sv
package tim_pkg;
    localparam int CNT_W = 14;
    localparam int NUM_SRC = 8;
    localparam int LVL_W = 3;
    localparam int IDX_W = 3;
    localparam int CTRL_W = 16;
    localparam int NEST_DIS_BIT = 15;
    localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;
    localparam logic [LVL_W-1:0] LVL_NONE = 3'h0;
    localparam logic [LVL_W-1:0] LVL_TOP = 3'h7;
    localparam logic [IDX_W-1:0] IDX_ZERO = 3'h0;

    typedef struct packed {
        logic flag;
        logic enable;
        logic [LVL_W-1:0] level;
    } source_t;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] index;
        logic [LVL_W-1:0] level;
    } pick_t;
endpackage

// >>> hw/priority_pick.sv
`timescale 1ns/1ps
`default_nettype none
module priority_pick
    import tim_pkg::*;
(
    input wire source_t [NUM_SRC-1:0] sources,
    input wire logic [LVL_W-1:0] cpu_level,
    input wire logic masked,
    output pick_t pick
);
    logic [NUM_SRC-1:0] eligible;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : g_elig
            // timed mask holds back levels 1 to 6 only; they stay pending
            assign eligible[g] = sources[g].flag && sources[g].enable
                && (sources[g].level > cpu_level) && (sources[g].level != LVL_NONE)
                && (!masked || sources[g].level == LVL_TOP);
        end
    endgenerate

    // highest level wins, lowest index on a tie
    always_comb
    begin
        pick = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (eligible[i] && (!pick.valid || sources[i].level >= pick.level))
            begin
                pick.valid = 1'b1;
                pick.index = IDX_W'(i);
                pick.level = sources[i].level;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/timed_interrupt_masking.sv
// Function
// - a timed mask with count n blocks for n+1 cycles, its own cycle being the first.
// - the counter takes the count at the end of the mask instruction and then counts down to zero.
// - a mask instruction while the counter is nonzero reloads it and blocking continues.
// - a mask instruction in the cycle the counter just reached zero loads but does not block.
// - the timed mask blocks only levels 1 to 6, and only in the instruction cycle and while the counter is nonzero.
// - writing zero to the counter ends the masking at once, unless a mask instruction comes in the same cycle.
// - nesting is enabled when bit 15 of interrupt control 1 is zero.
// - a source in service is negated by level, enable or flag changes.
// - negating a source in service under nesting, then a higher request, raises an address trap.
`timescale 1ns/1ps
`default_nettype none
module timed_interrupt_masking
    import tim_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic timed_interrupt_mask_instr,
    input wire logic [CNT_W-1:0] mask_count,
    input wire logic counter_wr,
    input wire logic [CNT_W-1:0] counter_wr_data,
    input wire logic [CTRL_W-1:0] interrupt_control_1,
    input wire logic [LVL_W-1:0] priority_level,
    input wire source_t [NUM_SRC-1:0] sources,
    input wire logic service_return,
    output logic [CNT_W-1:0] mask_cycle_counter,
    output logic masking_active,
    output logic irq_take,
    output logic [IDX_W-1:0] irq_index,
    output logic [LVL_W-1:0] irq_level,
    output logic in_service,
    output logic [LVL_W-1:0] service_level,
    output logic address_error_trap
);
    logic engaged_reg;
    logic just_zero_reg;
    logic negated_reg;
    logic [IDX_W-1:0] service_index_reg;
    logic masking;
    logic nest_en;
    logic take;
    logic hazard;
    logic neg_now;
    source_t cur;
    pick_t pick;

    assign nest_en = !interrupt_control_1[NEST_DIS_BIT];

    // the instruction cycle itself blocks, then the counted cycles
    assign masking = (mask_cycle_counter != CNT_ZERO && engaged_reg)
        || (timed_interrupt_mask_instr && !just_zero_reg);

    priority_pick u_pick (
        .sources(sources),
        .cpu_level(priority_level),
        .masked(masking),
        .pick(pick)
    );

    assign cur = sources[service_index_reg];
    assign neg_now = !cur.flag || !cur.enable || (cur.level <= priority_level);
    assign take = pick.valid && (!in_service || (nest_en && pick.level > service_level));
    assign hazard = in_service && nest_en && negated_reg;

    // instruction load beats a software write in the same cycle
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            mask_cycle_counter <= CNT_ZERO;
        else if (timed_interrupt_mask_instr)
            mask_cycle_counter <= mask_count;
        else if (counter_wr)
            mask_cycle_counter <= counter_wr_data;
        else if (mask_cycle_counter != CNT_ZERO)
            mask_cycle_counter <= mask_cycle_counter - CNT_ONE;
    end

    // marks the cycle right after a countdown reached zero
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            just_zero_reg <= 1'b0;
        else
            just_zero_reg <= (mask_cycle_counter == CNT_ONE)
                && !timed_interrupt_mask_instr && !counter_wr;
    end

    // silicon flaw kept on purpose: a load on that cycle does not re-engage
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            engaged_reg <= 1'b0;
        else if (timed_interrupt_mask_instr)
            engaged_reg <= !just_zero_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            masking_active <= 1'b0;
        else
            masking_active <= masking;
    end

    // one level of service only; return drops to idle, not to the preempted level
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            in_service <= 1'b0;
            service_level <= LVL_NONE;
            service_index_reg <= IDX_ZERO;
        end
        else if (take && !hazard)
        begin
            in_service <= 1'b1;
            service_level <= pick.level;
            service_index_reg <= pick.index;
        end
        else if (service_return)
        begin
            in_service <= 1'b0;
            service_level <= LVL_NONE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            irq_take <= 1'b0;
            irq_index <= IDX_ZERO;
            irq_level <= LVL_NONE;
        end
        else
        begin
            irq_take <= take && !hazard;
            if (take && !hazard)
            begin
                irq_index <= pick.index;
                irq_level <= pick.level;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            negated_reg <= 1'b0;
        else if (service_return || take || !in_service)
            negated_reg <= 1'b0;
        else if (neg_now)
            negated_reg <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            address_error_trap <= 1'b0;
        else
            address_error_trap <= take && hazard;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_count_load: assert property (
        timed_interrupt_mask_instr |=> mask_cycle_counter == $past(mask_count))
        else $error("counter not loaded by mask instruction");

    a_count_down: assert property (
        mask_cycle_counter != CNT_ZERO && !timed_interrupt_mask_instr && !counter_wr
        |=> mask_cycle_counter == $past(mask_cycle_counter) - CNT_ONE)
        else $error("counter did not step down");

    a_instr_blocks: assert property (
        timed_interrupt_mask_instr && !just_zero_reg |-> masking ##1 masking_active)
        else $error("mask instruction cycle not blocked");

    a_reload_holds: assert property (
        timed_interrupt_mask_instr && engaged_reg && mask_cycle_counter != CNT_ZERO
        && mask_count != CNT_ZERO |=> masking)
        else $error("reload dropped the mask");

    a_zero_defect: assert property (
        timed_interrupt_mask_instr && just_zero_reg
        |=> !masking || timed_interrupt_mask_instr)
        else $error("flawed reload still masked");

    a_end_at_zero: assert property (
        mask_cycle_counter == CNT_ZERO && !timed_interrupt_mask_instr |-> !masking)
        else $error("masking beyond counter zero");

    // the write lands at the edge, so masking_active still shows the write cycle once
    a_sw_clear: assert property (
        counter_wr && counter_wr_data == CNT_ZERO && !timed_interrupt_mask_instr
        |=> mask_cycle_counter == CNT_ZERO && (!masking || timed_interrupt_mask_instr))
        else $error("zero write did not end mask");

    a_top_level_free: assert property (
        masking && pick.valid |-> pick.level == LVL_TOP)
        else $error("masked level picked");

    a_no_nesting: assert property (
        interrupt_control_1[NEST_DIS_BIT] && in_service |=> !irq_take)
        else $error("preempted with nesting disabled");

    a_negate_seen: assert property (
        in_service && neg_now && !service_return && !take |=> negated_reg)
        else $error("negation not recorded");

    a_trap_cause: assert property (
        address_error_trap |-> $past(in_service && nest_en && negated_reg && pick.valid))
        else $error("trap without cause");
endmodule
`default_nettype wire

// >>> tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model
    import tim_pkg::*;
(
    output var source_t [NUM_SRC-1:0] sources
);
    logic [NUM_SRC-1:0] flag_reg = '0;
    // source i sits at level i, so index 7 is never blocked by masking
    always_comb
    begin
        for (int i = 0; i < NUM_SRC; i++)
        begin
            sources[i].flag = flag_reg[i];
            sources[i].enable = 1'b1;
            sources[i].level = LVL_W'(i);
        end
    end
    // service does not clear a flag; only software does
    task automatic set_flag(input int idx, input logic val);
        flag_reg[idx] = val;
    endtask
endmodule
`default_nettype wire

// >>> tb/timed_interrupt_masking_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timed_interrupt_masking_tb_top
    import tim_pkg::*;
;
    logic clk, reset_n, mask_instr, counter_wr, service_return;
    logic masking_active, irq_take, in_service, trap;
    logic [CNT_W-1:0] mask_count, wr_data, counter;
    logic [CTRL_W-1:0] ctrl;
    logic [LVL_W-1:0] cpu_lvl, irq_level, service_level;
    logic [IDX_W-1:0] irq_index;
    source_t [NUM_SRC-1:0] sources;
    int error_cnt = 0;
    int n_checks = 0;
    core_model core (.sources(sources));
    timed_interrupt_masking DUT (.clk(clk), .reset_n(reset_n),
        .timed_interrupt_mask_instr(mask_instr), .mask_count(mask_count),
        .counter_wr(counter_wr), .counter_wr_data(wr_data), .interrupt_control_1(ctrl),
        .priority_level(cpu_lvl), .sources(sources), .service_return(service_return),
        .mask_cycle_counter(counter), .masking_active(masking_active), .irq_take(irq_take),
        .irq_index(irq_index), .irq_level(irq_level), .in_service(in_service),
        .service_level(service_level), .address_error_trap(trap));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic mask(input logic [CNT_W-1:0] cnt);
        mask_instr = 1'b1;
        mask_count = cnt;
        step(1);
        mask_instr = 1'b0;
    endtask
    // bounded wait; exact cycle count is the point of most scenarios
    task automatic take_after(input int exp, input logic [IDX_W-1:0] idx);
        int n;
        n = 0;
        while (irq_take !== 1'b1 && n < 40)
        begin
            step(1);
            n++;
        end
        if (n == 40)
        begin
            error_cnt++;
            report_and_stop();
        end
        check(16'(n), 16'(exp));
        check(16'(irq_index), 16'(idx));
        check(16'(irq_level), 16'(idx));
    endtask
    task automatic finish(input int idx);
        core.set_flag(idx, 1'b0);
        service_return = 1'b1;
        step(1);
        service_return = 1'b0;
        check(16'(in_service), 16'h0000);
    endtask
    task automatic sc_defect();
        mask(14'h0001);
        step(1);
        core.set_flag(5, 1'b1);
        mask(14'h0003);
        take_after(0, 3'h5);
        check(16'(counter), 16'h0003);
        finish(5);
        step(4);
    endtask
    task automatic sc_normal();
        core.set_flag(4, 1'b1);
        mask(14'h0002);
        for (int i = 0; i < 4; i++)
        begin
            if (i > 0)
                step(1);
            check(16'(counter), 16'(i < 3 ? 2 - i : 0));
            check(16'({irq_take, masking_active}), 16'(i == 3 ? 2 : 1));
        end
        finish(4);
    endtask
    task automatic sc_reload();
        mask(14'h0003);
        step(1);
        core.set_flag(2, 1'b1);
        mask(14'h0003);
        check(16'(counter), 16'h0003);
        take_after(4, 3'h2);
        finish(2);
    endtask
    task automatic sc_top_level();
        core.set_flag(7, 1'b1);
        mask(14'h0005);
        take_after(0, 3'h7);
        finish(7);
        step(6);
    endtask
    task automatic sc_write_zero();
        core.set_flag(3, 1'b1);
        mask(14'h0064);
        step(1);
        counter_wr = 1'b1;
        wr_data = 14'h0000;
        step(1);
        counter_wr = 1'b0;
        take_after(1, 3'h3);
        finish(3);
    endtask
    task automatic sc_negated();
        cpu_lvl = 3'h4;
        core.set_flag(4, 1'b1);
        step(3);
        check(16'(in_service), 16'h0000);
        cpu_lvl = 3'h3;
        take_after(1, 3'h4);
        cpu_lvl = 3'h0;
        finish(4);
    endtask
    task automatic sc_nesting();
        core.set_flag(3, 1'b1);
        take_after(1, 3'h3);
        core.set_flag(5, 1'b1);
        // the first take pulse still stands here; let it pass first
        step(1);
        take_after(0, 3'h5);
        core.set_flag(3, 1'b0);
        finish(5);
        core.set_flag(3, 1'b1);
        take_after(1, 3'h3);
        core.set_flag(3, 1'b0);
        step(1);
        core.set_flag(6, 1'b1);
        step(1);
        check(16'({trap, irq_take, service_level}), 16'h0013);
        ctrl = 16'h8000;
        step(1);
        check(16'({trap, irq_take, service_level}), 16'h0003);
        finish(6);
        ctrl = 16'h0000;
    endtask
    initial
    begin
        {reset_n, mask_instr, counter_wr, service_return} = 4'h0;
        {mask_count, wr_data, ctrl, cpu_lvl} = '0;
        step(5);
        check(16'({counter, in_service, irq_take}), 16'h0000);
        reset_n = 1'b1;
        sc_defect();
        sc_normal();
        sc_reload();
        sc_top_level();
        sc_write_zero();
        sc_negated();
        sc_nesting();
        report_and_stop();
    end
endmodule
`default_nettype wire
